// File: tc_pkg.sv
package tc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on the AHB-Lite bus).
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_FIFO = 8'h0C;
  localparam logic [7:0] ADDR_APER = 8'h10;
  localparam logic [7:0] ADDR_RES_X = 8'h20;
  localparam logic [7:0] ADDR_RES_Y = 8'h24;
  localparam logic [7:0] ADDR_RES_Z1 = 8'h28;
  localparam logic [7:0] ADDR_RES_Z2 = 8'h2C;

  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int CFG_AUTO_BIT = 0;
  localparam int CFG_EDGE_BIT = 1;
  localparam int CFG_GROUP_LSB = 2;
  localparam int CFG_PULSE_LSB = 8;
  localparam int CFG_CHECK_LSB = 16;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_HOLD_BIT = 2;
  localparam int CMD_GROUP_LSB = 4;
  localparam int CMD_CLASS_LSB = 8;
  localparam int ST_IRQ_BIT = 0;
  localparam int ST_TOUCH_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_FCNT_LSB = 8;
  localparam logic [31:0] CONFIG_RST = 32'h0008_0400;
  localparam logic [11:0] APER_RST = 12'h000;
  localparam logic [15:0] WORD_PENDING = 16'hFFFF;

  // ----------------------------------------------------------------------
  // Timing: all programmable durations count in microsecond ticks.
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Encodings.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CLS_PREP = 2'h0, CLS_MEASURE = 2'h1, CLS_GROUP = 2'h2} tc_class_e;
  typedef enum logic [1:0] {KIND_X = 2'h0, KIND_Y = 2'h1, KIND_Z1 = 2'h2, KIND_Z2 = 2'h3} tc_kind_e;
  typedef enum logic [1:0] {EVT_TOUCH = 2'h0, EVT_MID = 2'h1, EVT_RELEASE = 2'h2, EVT_BUSY = 2'h3} tc_event_e;
  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_CONV = 3'h1,
    ST_CHECK = 3'h3,
    ST_SLEEP = 3'h2,
    ST_PREP = 3'h6
  } tc_state_e;

  // ----------------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic start;
    tc_kind_e kind;
  } tc_adc_req_s;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } tc_adc_rsp_s;

  typedef struct packed {
    logic on;
    tc_kind_e kind;
  } tc_panel_s;

  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [15:0] data;
  } tc_mem_wr_s;

endpackage

// File: tc_mem.sv
`timescale 1ns/1ps
module tc_mem (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Write port.
  input wire tc_pkg::tc_mem_wr_s wr,
  // Read port.
  input wire logic [3:0] raddr,
  output logic [15:0] rdata
);

  // ----------------------------------------------------------------------
  // Storage: words 0 to 3 are direct results, 8 to 15 the scan FIFO.
  // ----------------------------------------------------------------------
  logic [15:0] mem [16];

  always_ff @(posedge hclk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// File: tc_ctrl.sv
`timescale 1ns/1ps
// Operation
// R1: auto scan logs each result, interrupts per entry
// R2: host may read scan FIFO any time
// R3: auto scan aperture suppresses nearby repeated positions
// R4: direct accepts prep, measure, grouped; auto groups
// R5: grouped runs X-Y, X-Y-Z1 or X-Y-Z1-Z2
// R6: two interrupt schemes selected by configuration
// R7: level mode waits, drives interrupt on touch
// R8: level interrupt stays low during host operations
// R9: after unheld measurement recheck touch, then tag
// R10: level mode returns to waiting, line follows touch
// R11: level tags: touch, unused, no touch, busy
// R12: edge mode sleeps untimed while touch persists
// R13: edge tags: initial, midpress, release then wait
// R14: edge interrupt is a configured fixed pulse
// R15: edge sleeps on 00/01, waits on 10
// R16: no release tag means no new interrupts
// R17: host keeps converting unheld until release seen
// R18: host may poll status for pending interrupt
// R19: result word: data, kind tag, event tag
// R20: pending results read all ones until done
// R21: held measurement keeps setup, interrupt untouched
module tc_ctrl (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel, converter and interrupt.
  input wire logic touch_detect,
  input wire tc_pkg::tc_adc_rsp_s adc_rsp,
  output tc_pkg::tc_adc_req_s adc_req,
  output tc_pkg::tc_panel_s panel,
  output logic touch_irq_n
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    tc_pkg::tc_state_e state;
    logic irq_n;
    logic rdy;
    logic [31:0] rdata;
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] cfg;
    logic [11:0] aper;
    logic touch_s1;
    logic touch_s2;
    logic touch_prev;
    logic [7:0] pulse_cnt;
    logic [5:0] tick_cnt;
    logic [7:0] chk_cnt;
    tc_pkg::tc_kind_e seq_kind;
    tc_pkg::tc_kind_e seq_last;
    logic hold;
    logic initial_touch;
    logic [3:0] pend;
    logic [7:0] evt;
    logic irq_pend;
    logic [2:0] wptr;
    logic [2:0] rptr;
    logic [3:0] fcnt;
    logic [11:0] last_x;
    logic [11:0] last_y;
    tc_pkg::tc_adc_req_s adc;
    tc_pkg::tc_panel_s pnl;
  } tc_ctrl_s;

  tc_ctrl_s st_r;
  tc_ctrl_s st_nxt;
  tc_pkg::tc_mem_wr_s mem_wr;
  logic [3:0] mem_raddr;
  logic [15:0] mem_rdata;

  tc_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(mem_wr),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  function automatic logic near(input logic [11:0] a, input logic [11:0] b, input logic [11:0] ap);
    logic [11:0] d;
    d = (a > b) ? a - b : b - a;
    return d < ap;
  endfunction

  function automatic logic [3:0] kinds_upto(input tc_pkg::tc_kind_e last);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      m[i] = (2'(i) <= last);
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  logic addr_ph;
  logic tick;
  logic auto_m;
  logic edge_m;
  logic touch;
  logic rise;
  logic cmd_wr;
  logic [1:0] slot;
  logic [1:0] ftag;
  logic log_ok;
  tc_pkg::tc_event_e fin_tag;

  assign addr_ph = hsel && htrans[1] && hready;
  assign mem_raddr = (haddr == tc_pkg::ADDR_FIFO) ? {1'b1, st_r.rptr} : {2'b00, haddr[3:2]};

  always_comb begin
    st_nxt = st_r;
    mem_wr = '0;
    auto_m = st_r.cfg[tc_pkg::CFG_AUTO_BIT];
    edge_m = st_r.cfg[tc_pkg::CFG_EDGE_BIT];
    touch = st_r.touch_s2;
    rise = touch && !st_r.touch_prev;
    tick = (st_r.tick_cnt == 6'(tc_pkg::TICK_CYC - 1));
    slot = st_r.seq_kind;
    ftag = 2'(tc_pkg::EVT_TOUCH);
    log_ok = 1'b0;
    fin_tag = tc_pkg::EVT_RELEASE;
    st_nxt.touch_s1 = touch_detect;
    st_nxt.touch_s2 = st_r.touch_s1;
    st_nxt.touch_prev = touch;
    st_nxt.tick_cnt = tick ? 6'h00 : st_r.tick_cnt + 6'h01;
    st_nxt.adc.start = 1'b0;
    st_nxt.rdy = 1'b1;
    if (tick && st_r.pulse_cnt != 8'h00) begin
      st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
    end
    // Bus address phase; reads take one wait state for the registered memory.
    if (addr_ph) begin
      st_nxt.dp_valid = 1'b1;
      st_nxt.dp_write = hwrite;
      st_nxt.dp_addr = haddr;
      st_nxt.rdy = hwrite;
    end else if (st_r.rdy) begin
      st_nxt.dp_valid = 1'b0;
    end
    cmd_wr = st_r.dp_valid && st_r.dp_write && st_r.rdy && st_r.dp_addr == tc_pkg::ADDR_CMD;
    if (st_r.dp_valid && st_r.dp_write && st_r.rdy) begin
      case (st_r.dp_addr)
        tc_pkg::ADDR_CONFIG: st_nxt.cfg = hwdata; // see R6
        tc_pkg::ADDR_APER: st_nxt.aper = hwdata[11:0]; // see R3
        default: st_nxt.cfg = st_nxt.cfg;
      endcase
    end
    if (st_r.dp_valid && !st_r.dp_write && !st_r.rdy) begin
      st_nxt.rdata = 32'h0000_0000;
      case (st_r.dp_addr)
        tc_pkg::ADDR_STATUS: begin
          st_nxt.rdata[tc_pkg::ST_IRQ_BIT] = st_r.irq_pend; // see R18
          st_nxt.rdata[tc_pkg::ST_TOUCH_BIT] = touch;
          st_nxt.rdata[tc_pkg::ST_BUSY_BIT] = (st_r.state == tc_pkg::ST_CONV || st_r.state == tc_pkg::ST_CHECK);
          st_nxt.rdata[tc_pkg::ST_STATE_LSB +: 3] = st_r.state;
          st_nxt.rdata[tc_pkg::ST_FCNT_LSB +: 4] = st_r.fcnt;
          st_nxt.irq_pend = 1'b0;
        end
        tc_pkg::ADDR_CONFIG: st_nxt.rdata = st_r.cfg;
        tc_pkg::ADDR_APER: st_nxt.rdata[11:0] = st_r.aper;
        tc_pkg::ADDR_FIFO: begin
          if (st_r.fcnt != 4'h0) begin // see R2
            st_nxt.rdata[15:0] = mem_rdata;
            st_nxt.rptr = st_r.rptr + 3'h1;
            st_nxt.fcnt = st_r.fcnt - 4'h1;
          end else begin
            st_nxt.rdata[15:0] = tc_pkg::WORD_PENDING;
          end
        end
        tc_pkg::ADDR_RES_X, tc_pkg::ADDR_RES_Y, tc_pkg::ADDR_RES_Z1, tc_pkg::ADDR_RES_Z2: begin
          if (st_r.pend[st_r.dp_addr[3:2]]) begin
            st_nxt.rdata[15:0] = tc_pkg::WORD_PENDING; // see R20
          end else begin
            st_nxt.rdata[15:0] = {mem_rdata[15:2], st_r.evt[2 * st_r.dp_addr[3:2] +: 2]}; // see R19
          end
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Interrupt line and sticky pending flag; a new event beats the status read clear.
    if (edge_m || auto_m) begin
      if (st_r.state == tc_pkg::ST_WAIT && rise && !auto_m) begin
        st_nxt.pulse_cnt = st_r.cfg[tc_pkg::CFG_PULSE_LSB +: 8]; // see R14
        st_nxt.initial_touch = 1'b1;
        st_nxt.irq_pend = 1'b1; // see R13
      end
      st_nxt.irq_n = (st_r.pulse_cnt == 8'h00);
    end else if (st_r.state == tc_pkg::ST_WAIT) begin // see R8
      st_nxt.irq_n = !touch; // see R7 R10
      if (rise) begin
        st_nxt.irq_pend = 1'b1;
      end
    end
    // Sequencer.
    case (st_r.state)
      tc_pkg::ST_WAIT, tc_pkg::ST_SLEEP, tc_pkg::ST_PREP: begin
        if (auto_m && st_r.state == tc_pkg::ST_WAIT && touch) begin
          st_nxt.seq_kind = tc_pkg::KIND_X; // see R4
          st_nxt.seq_last = tc_pkg::tc_kind_e'(st_r.cfg[tc_pkg::CFG_GROUP_LSB +: 2] + 2'h1);
          st_nxt.hold = 1'b0;
          st_nxt.initial_touch = st_r.initial_touch || rise;
          st_nxt.adc.start = 1'b1;
          st_nxt.adc.kind = tc_pkg::KIND_X;
          st_nxt.pnl.on = 1'b1;
          st_nxt.pnl.kind = tc_pkg::KIND_X;
          st_nxt.state = tc_pkg::ST_CONV;
        end else if (cmd_wr && !auto_m) begin
          case (tc_pkg::tc_class_e'(hwdata[tc_pkg::CMD_CLASS_LSB +: 2]))
            tc_pkg::CLS_PREP: begin
              st_nxt.pnl.on = 1'b1;
              st_nxt.pnl.kind = tc_pkg::tc_kind_e'(hwdata[tc_pkg::CMD_KIND_LSB +: 2]);
              st_nxt.state = tc_pkg::ST_PREP;
            end
            tc_pkg::CLS_MEASURE: begin
              st_nxt.seq_kind = tc_pkg::tc_kind_e'(hwdata[tc_pkg::CMD_KIND_LSB +: 2]);
              st_nxt.seq_last = tc_pkg::tc_kind_e'(hwdata[tc_pkg::CMD_KIND_LSB +: 2]);
              st_nxt.hold = hwdata[tc_pkg::CMD_HOLD_BIT];
              st_nxt.pend[hwdata[tc_pkg::CMD_KIND_LSB +: 2]] = 1'b1;
              st_nxt.adc.start = 1'b1;
              st_nxt.adc.kind = tc_pkg::tc_kind_e'(hwdata[tc_pkg::CMD_KIND_LSB +: 2]);
              st_nxt.pnl.on = 1'b1;
              st_nxt.pnl.kind = tc_pkg::tc_kind_e'(hwdata[tc_pkg::CMD_KIND_LSB +: 2]);
              st_nxt.state = tc_pkg::ST_CONV;
            end
            tc_pkg::CLS_GROUP: begin
              st_nxt.seq_kind = tc_pkg::KIND_X; // see R5
              st_nxt.seq_last = tc_pkg::tc_kind_e'(hwdata[tc_pkg::CMD_GROUP_LSB +: 2] + 2'h1);
              st_nxt.hold = 1'b0;
              st_nxt.pend = st_r.pend | kinds_upto(tc_pkg::tc_kind_e'(hwdata[tc_pkg::CMD_GROUP_LSB +: 2] + 2'h1));
              st_nxt.adc.start = 1'b1;
              st_nxt.adc.kind = tc_pkg::KIND_X;
              st_nxt.pnl.on = 1'b1;
              st_nxt.pnl.kind = tc_pkg::KIND_X;
              st_nxt.state = tc_pkg::ST_CONV;
            end
            default: st_nxt.state = st_r.state;
          endcase
        end
      end
      tc_pkg::ST_CONV: begin
        if (adc_rsp.done) begin
          if (auto_m) begin
            ftag = st_r.initial_touch ? 2'(tc_pkg::EVT_TOUCH) : 2'(tc_pkg::EVT_MID);
            log_ok = st_r.fcnt != 4'h8;
            if (!st_r.initial_touch && st_r.seq_kind == tc_pkg::KIND_X) begin
              log_ok = log_ok && !near(adc_rsp.data, st_r.last_x, st_r.aper); // see R3
            end
            if (!st_r.initial_touch && st_r.seq_kind == tc_pkg::KIND_Y) begin
              log_ok = log_ok && !near(adc_rsp.data, st_r.last_y, st_r.aper); // see R3
            end
            if (log_ok) begin
              mem_wr.en = 1'b1; // see R1
              mem_wr.addr = {1'b1, st_r.wptr};
              mem_wr.data = {adc_rsp.data, st_r.seq_kind, ftag};
              st_nxt.wptr = st_r.wptr + 3'h1;
              st_nxt.fcnt = st_nxt.fcnt + 4'h1;
              st_nxt.pulse_cnt = st_r.cfg[tc_pkg::CFG_PULSE_LSB +: 8]; // see R1
              st_nxt.irq_pend = 1'b1;
              if (st_r.seq_kind == tc_pkg::KIND_X) begin
                st_nxt.last_x = adc_rsp.data;
              end
              if (st_r.seq_kind == tc_pkg::KIND_Y) begin
                st_nxt.last_y = adc_rsp.data;
              end
            end
          end else begin
            mem_wr.en = 1'b1;
            mem_wr.addr = {2'b00, slot};
            mem_wr.data = {adc_rsp.data, st_r.seq_kind, 2'(tc_pkg::EVT_TOUCH)}; // see R19 R11
          end
          if (st_r.seq_kind != st_r.seq_last) begin
            st_nxt.seq_kind = tc_pkg::tc_kind_e'(st_r.seq_kind + 2'h1); // see R5
            st_nxt.adc.start = 1'b1;
            st_nxt.adc.kind = tc_pkg::tc_kind_e'(st_r.seq_kind + 2'h1);
            st_nxt.pnl.kind = tc_pkg::tc_kind_e'(st_r.seq_kind + 2'h1);
          end else if (st_r.hold) begin
            st_nxt.pend[slot] = 1'b0; // see R21
            st_nxt.evt[2 * slot +: 2] = 2'(tc_pkg::EVT_TOUCH);
            st_nxt.state = tc_pkg::ST_PREP;
          end else begin
            st_nxt.pnl.on = 1'b0;
            st_nxt.chk_cnt = st_r.cfg[tc_pkg::CFG_CHECK_LSB +: 8]; // see R9
            st_nxt.state = tc_pkg::ST_CHECK;
          end
        end
      end
      tc_pkg::ST_CHECK: begin
        if (tick && st_r.chk_cnt != 8'h00) begin
          st_nxt.chk_cnt = st_r.chk_cnt - 8'h01;
        end else if (st_r.chk_cnt == 8'h00) begin
          if (touch) begin
            fin_tag = (edge_m && !st_r.initial_touch) ? tc_pkg::EVT_MID : tc_pkg::EVT_TOUCH; // see R11 R13
          end
          for (int i = 0; i < 4; i++) begin
            if (st_r.pend[i]) begin
              st_nxt.evt[2 * i +: 2] = fin_tag; // see R9 R20
            end
          end
          st_nxt.pend = 4'h0;
          st_nxt.initial_touch = 1'b0;
          if (edge_m && !auto_m && touch) begin
            st_nxt.state = tc_pkg::ST_SLEEP; // see R12 R15 R16
          end else begin
            st_nxt.state = tc_pkg::ST_WAIT; // see R10 R15
          end
        end
      end
      default: st_nxt.state = tc_pkg::ST_WAIT;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers and outputs.
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.state <= tc_pkg::ST_WAIT;
      st_r.irq_n <= 1'b1;
      st_r.rdy <= 1'b1;
      st_r.cfg <= tc_pkg::CONFIG_RST;
      st_r.aper <= tc_pkg::APER_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.rdy;
  assign hresp = 1'b0;
  assign adc_req = st_r.adc;
  assign panel = st_r.pnl;
  assign touch_irq_n = st_r.irq_n;

endmodule

// File: tc_ctrl_properties.sv
`timescale 1ns/1ps
module tc_ctrl_properties (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Panel, converter and interrupt.
  input wire logic touch_detect,
  input wire tc_pkg::tc_adc_rsp_s adc_rsp,
  input wire tc_pkg::tc_adc_req_s adc_req,
  input wire tc_pkg::tc_panel_s panel,
  input wire logic touch_irq_n
);
  logic [3:0] hist_r;
  logic cfg_r;
  logic edge_r;
  logic auto_r;
  int pulse_r;
  int low_r;
  wire logic req = hsel && htrans[1] && hready;

  // Shadow of the mode fields, taken from configuration writes on the bus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_r <= 4'h0;
      cfg_r <= 1'b0;
      edge_r <= tc_pkg::CONFIG_RST[tc_pkg::CFG_EDGE_BIT];
      auto_r <= tc_pkg::CONFIG_RST[tc_pkg::CFG_AUTO_BIT];
      pulse_r <= int'(tc_pkg::CONFIG_RST[tc_pkg::CFG_PULSE_LSB +: 8]);
      low_r <= 0;
    end else begin
      hist_r <= {hist_r[2:0], touch_detect};
      cfg_r <= req && hwrite && haddr == tc_pkg::ADDR_CONFIG;
      low_r <= touch_irq_n ? 0 : low_r + 1;
      if (cfg_r) begin
        edge_r <= hwdata[tc_pkg::CFG_EDGE_BIT];
        auto_r <= hwdata[tc_pkg::CFG_AUTO_BIT];
        pulse_r <= int'(hwdata[tc_pkg::CFG_PULSE_LSB +: 8]);
      end
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bus_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
  read_wait_a: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  write_nowait_a: assert property (req && hwrite |=> hreadyout) else $error("write was stalled");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("read data moved");
  start_pulse_a: assert property (adc_req.start |=> !adc_req.start until adc_rsp.done)
    else $error("converter started again before answer");
  level_hold_a: assert property (
    !edge_r && !auto_r && !touch_irq_n && adc_req.start |=> !touch_irq_n until adc_rsp.done)
    else $error("level interrupt released during measurement");
  irq_cause_a: assert property (!auto_r && $fell(touch_irq_n) |-> hist_r != 4'h0)
    else $error("interrupt without touch");
  edge_width_a: assert property (
    edge_r && !auto_r && $rose(touch_irq_n) |->
    low_r + tc_pkg::TICK_CYC >= pulse_r * tc_pkg::TICK_CYC && low_r <= (pulse_r + 1) * tc_pkg::TICK_CYC)
    else $error("edge interrupt pulse width wrong");

  cover property (req && !hwrite);
  cover property (edge_r && $rose(touch_irq_n));
  cover property (!edge_r && !touch_irq_n && adc_req.start);
endmodule

bind tc_ctrl tc_ctrl_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .touch_detect(touch_detect), .adc_rsp(adc_rsp), .adc_req(adc_req),
  .panel(panel), .touch_irq_n(touch_irq_n));

// File: tc_adc_model.sv
`timescale 1ns/1ps
module tc_adc_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Converter request and answer.
  input wire tc_pkg::tc_adc_req_s adc_req,
  output tc_pkg::tc_adc_rsp_s adc_rsp,
  // Bench controls.
  input wire logic [3:0] lat,
  input wire logic [11:0] base
);
  logic busy_r;
  logic [3:0] cnt_r;
  logic [11:0] last_r;
  logic [1:0] kind_r;

  // Outside an answer the data lines show the inverse of the last result.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      last_r <= 12'h000;
      kind_r <= 2'h0;
      adc_rsp <= '0;
    end else if (adc_req.start) begin
      busy_r <= 1'b1;
      cnt_r <= lat;
      kind_r <= adc_req.kind;
      adc_rsp <= {1'b0, ~last_r};
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      last_r <= base ^ {10'h000, kind_r};
      adc_rsp <= {1'b1, base ^ {10'h000, kind_r}};
    end else begin
      cnt_r <= busy_r ? cnt_r - 4'h1 : cnt_r;
      adc_rsp <= {1'b0, ~last_r};
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic touch_detect;
  logic touch_irq_n;
  tc_pkg::tc_adc_req_s adc_req;
  tc_pkg::tc_adc_rsp_s adc_rsp;
  tc_pkg::tc_panel_s panel;
  logic [3:0] lat;
  logic [11:0] base;
  logic [31:0] rnd;
  logic [31:0] rd;
  logic [15:0] exp_q[$];
  int err_count;
  int num_checks;
  int n;

  tc_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .touch_detect(touch_detect), .adc_rsp(adc_rsp), .adc_req(adc_req), .panel(panel), .touch_irq_n(touch_irq_n));
  tc_adc_model u_adc (.hclk(hclk), .hresetn(hresetn), .adc_req(adc_req), .adc_rsp(adc_rsp), .lat(lat), .base(base));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, rd);
    chk(rd, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, rd);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      bus(tc_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
      k++;
    end while (rd[tc_pkg::ST_BUSY_BIT] !== 1'b0 && k < 300);
    chk({31'h0, rd[tc_pkg::ST_BUSY_BIT]}, 32'h0);
  endtask

  task automatic wait_irq(input logic lvl);
    int k;
    k = 0;
    while (touch_irq_n !== lvl && k < 300) begin
      @(posedge hclk);
      k++;
    end
    chk({31'h0, touch_irq_n}, {31'h0, lvl});
  endtask

  // Runs one measurement or grouped command and compares every result word with the model.
  task automatic run(input logic [1:0] cls, input logic [1:0] grp, input logic [1:0] kind, input logic [1:0] evt);
    logic [1:0] k;
    int m;
    rnd = xs(rnd);
    base <= rnd[11:0];
    lat <= rnd[15:12];
    m = (cls == tc_pkg::CLS_GROUP) ? int'(grp) + 2 : 1;
    for (int i = 0; i < m; i++) begin
      k = (cls == tc_pkg::CLS_GROUP) ? 2'(i) : kind;
      exp_q.push_back({rnd[11:0] ^ {10'h0, k}, k, evt});
    end
    wr(tc_pkg::ADDR_CMD, {22'h0, cls, 2'h0, grp, 1'b0, 1'b0, kind});
    k = (cls == tc_pkg::CLS_GROUP) ? 2'h0 : kind;
    rchk(tc_pkg::ADDR_RES_X + {4'h0, k, 2'h0}, 32'h0000_FFFF);
    wait_idle();
    for (int i = 0; i < m; i++) begin
      k = exp_q[0][3:2];
      rchk(tc_pkg::ADDR_RES_X + {4'h0, k, 2'h0}, {16'h0, exp_q.pop_front()});
    end
  endtask

  initial begin
    #2_000_000;
    err_count++;
    close_out();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    touch_detect = 1'b0;
    lat = 4'h0;
    base = 12'h000;
    rnd = 32'hC72A;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(tc_pkg::ADDR_CONFIG, tc_pkg::CONFIG_RST);
    wr(8'h3C, 32'hFFFF_FFFF);
    rchk(8'h3C, 32'h0);
    wr(tc_pkg::ADDR_APER, 32'hFFFF_FFFF);
    rchk(tc_pkg::ADDR_APER, 32'h0000_0FFF);
    wr(tc_pkg::ADDR_CONFIG, 32'h0002_0400);
    touch_detect <= 1'b1;
    wait_irq(1'b0);
    for (int g = 0; g < 3; g++) run(tc_pkg::CLS_GROUP, 2'(g), 2'h0, 2'h0);
    for (int k = 0; k < 4; k++) begin
      wr(tc_pkg::ADDR_CMD, {22'h0, tc_pkg::CLS_PREP, 6'h0, 2'(k)});
      run(tc_pkg::CLS_MEASURE, 2'h0, 2'(k), 2'h0);
    end
    wr(tc_pkg::ADDR_CMD, {22'h0, tc_pkg::CLS_MEASURE, 5'h0, 1'b1, 2'h1});
    wait_idle();
    chk({31'h0, panel.on}, 32'h1);
    chk({30'h0, panel.kind}, 32'h1);
    chk({31'h0, touch_irq_n}, 32'h0);
    touch_detect <= 1'b0;
    run(tc_pkg::CLS_MEASURE, 2'h0, 2'h1, 2'h2);
    wait_irq(1'b1);
    wr(tc_pkg::ADDR_CONFIG, 32'h0002_0202);
    touch_detect <= 1'b1;
    wait_irq(1'b0);
    bus(tc_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
    chk({31'h0, rd[tc_pkg::ST_IRQ_BIT]}, 32'h1);
    wait_irq(1'b1);
    run(tc_pkg::CLS_MEASURE, 2'h0, 2'h0, 2'h0);
    run(tc_pkg::CLS_MEASURE, 2'h0, 2'h1, 2'h1);
    bus(tc_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
    chk({29'h0, rd[6:4]}, {29'h0, tc_pkg::ST_SLEEP});
    touch_detect <= 1'b0;
    repeat (200) @(posedge hclk);
    touch_detect <= 1'b1;
    n = 0;
    repeat (400) begin
      @(posedge hclk);
      if (touch_irq_n !== 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    touch_detect <= 1'b0;
    run(tc_pkg::CLS_MEASURE, 2'h0, 2'h0, 2'h2);
    bus(tc_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
    chk({29'h0, rd[6:4]}, {29'h0, tc_pkg::ST_WAIT});
    touch_detect <= 1'b1;
    wait_irq(1'b0);
    wait_irq(1'b1);
    touch_detect <= 1'b0;
    repeat (200) @(posedge hclk);
    wr(tc_pkg::ADDR_CONFIG, 32'h0002_0401);
    touch_detect <= 1'b1;
    repeat (3000) @(posedge hclk);
    bus(tc_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
    chk({31'h0, rd[tc_pkg::ST_IRQ_BIT]}, 32'h1);
    chk({28'h0, rd[11:8]}, 32'h2);
    for (int k = 0; k < 2; k++) begin
      bus(tc_pkg::ADDR_FIFO, 1'b0, 32'h0, rd);
      chk({18'h0, rd[15:2]}, {18'h0, base ^ 12'(k), 2'(k)});
    end
    rchk(tc_pkg::ADDR_FIFO, 32'h0000_FFFF);
    close_out();
  end
endmodule
